// >>> core/frs_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_defs.svh"
module frs_host #(
	parameter int SUPPLY_CYC = `FRS_SUPPLY_CYC,
	parameter int RPH_CYC = `FRS_RPH_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_reset_req,
	input wire logic i_access_req,
	input wire logic i_access_end,
	input wire logic i_ready_busy_n,
	output logic o_hw_reset_n,
	output logic o_chip_select_n,
	output logic o_ready,
	output logic o_busy
);
	frs_pkg::frs_state_e st_reg;
	frs_pkg::frs_state_e st_next;
	logic ld;
	frs_pkg::frs_cnt_t ld_val;
	logic done;
	logic rst_n_reg;
	logic rst_n_next;
	logic cs_n_reg;
	logic cs_n_next;
	logic cold_done_reg;
	logic cold_done_next;
	logic boot_reg;
	logic boot_next;
	localparam int RPW = (`FRS_RP_CYC + `FRS_RH_CYC < RPH_CYC) ? RPH_CYC - `FRS_RH_CYC
		: `FRS_RP_CYC;
	frs_timer u_frs_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_load(ld),
		.i_count(ld_val),
		.o_done(done)
	);
	always_comb begin
		st_next = st_reg;
		rst_n_next = rst_n_reg;
		cs_n_next = cs_n_reg;
		cold_done_next = cold_done_reg;
		ld = 1'b0;
		ld_val = 16'h0000;
		case (st_reg)
			frs_pkg::FRS_ST_POWER: begin
				// Controls held quiet since device ignores them now
				if (boot_reg) begin
					// Every release of reset restarts the full supply wait
					ld = 1'b1;
					ld_val = 16'(SUPPLY_CYC);
				end else if (done) begin
					cold_done_next = 1'b1;
					ld = 1'b1;
					ld_val = 16'(`FRS_RH_CYC);
					st_next = frs_pkg::FRS_ST_RST_HIGH;
				end
			end
			frs_pkg::FRS_ST_RST_LOW: begin
				// Pulse width stretched so pulse plus high time covers warm reset
				if (done) begin
					rst_n_next = 1'b1;
					ld = 1'b1;
					ld_val = 16'(RPH_CYC - RPW);
					st_next = frs_pkg::FRS_ST_RST_WAIT;
				end
			end
			frs_pkg::FRS_ST_RST_WAIT: begin
				if (done) begin
					ld = 1'b1;
					ld_val = 16'(`FRS_RH_CYC);
					st_next = frs_pkg::FRS_ST_RST_HIGH;
				end
			end
			frs_pkg::FRS_ST_RST_HIGH: begin
				if (done && i_ready_busy_n) begin
					st_next = frs_pkg::FRS_ST_READY;
				end
			end
			frs_pkg::FRS_ST_READY: begin
				if (i_reset_req) begin
					rst_n_next = 1'b0;
					ld = 1'b1;
					ld_val = 16'(RPW);
					// Unfinished cold start: full cold time again
					if (!cold_done_reg) begin
						ld_val = 16'(SUPPLY_CYC);
						st_next = frs_pkg::FRS_ST_POWER;
					end else begin
						st_next = frs_pkg::FRS_ST_RST_LOW;
					end
					cs_n_next = 1'b1;
				end else if (i_access_req && cs_n_reg) begin
					cs_n_next = 1'b0;
				end else if (i_access_end && !cs_n_reg) begin
					cs_n_next = 1'b1;
					ld = 1'b1;
					ld_val = 16'(`FRS_CEH_CYC);
					st_next = frs_pkg::FRS_ST_SEL_HIGH;
				end
			end
			frs_pkg::FRS_ST_SEL_HIGH: begin
				if (done) begin
					st_next = frs_pkg::FRS_ST_READY;
				end
			end
			default: begin
				st_next = frs_pkg::FRS_ST_POWER;
			end
		endcase
		// Leaving cold start with reset low restarts the reset timing
		if (st_reg == frs_pkg::FRS_ST_POWER && done && !rst_n_reg) begin
			ld_val = 16'(RPH_CYC);
			st_next = frs_pkg::FRS_ST_RST_WAIT;
			rst_n_next = 1'b1;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st_reg <= frs_pkg::FRS_ST_POWER;
			rst_n_reg <= 1'b1;
			cs_n_reg <= 1'b1;
			cold_done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			rst_n_reg <= rst_n_next;
			cs_n_reg <= cs_n_next;
			cold_done_reg <= cold_done_next;
		end
	end
	// Boot flag marks the first cycle after reset, when the cold wait is loaded
	always_comb begin
		boot_next = 1'b0;
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= boot_next;
		end
	end
	assign o_hw_reset_n = rst_n_reg;
	assign o_chip_select_n = cs_n_reg;
	assign o_ready = (st_reg == frs_pkg::FRS_ST_READY);
	assign o_busy = !o_ready;
	int cyc_reg;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cyc_reg <= 0;
		end else if (st_reg != frs_pkg::FRS_ST_READY && !cs_n_reg) begin
			cyc_reg <= cyc_reg + 1;
		end else begin
			cyc_reg <= 0;
		end
	end
	property p_sel_high_in_reset;
		@(posedge i_clk_sys) disable iff (i_rst)
		!o_hw_reset_n |-> o_chip_select_n;
	endproperty
	a_sel_high_in_reset: assert property (p_sel_high_in_reset) else $error("select low in reset");
	property p_ceh;
		@(posedge i_clk_sys) disable iff (i_rst)
		$rose(o_chip_select_n) && o_hw_reset_n |-> o_chip_select_n[*2];
	endproperty
	a_ceh: assert property (p_ceh) else $error("select high too short");
	property p_rh;
		@(posedge i_clk_sys) disable iff (i_rst)
		$rose(o_hw_reset_n) |-> o_chip_select_n[*2];
	endproperty
	a_rh: assert property (p_rh) else $error("select low too soon after reset");
	property p_rp;
		@(posedge i_clk_sys) disable iff (i_rst)
		$fell(o_hw_reset_n) |-> !o_hw_reset_n[*5];
	endproperty
	a_rp: assert property (p_rp) else $error("reset pulse too short");
	property p_no_access_cold;
		@(posedge i_clk_sys) disable iff (i_rst)
		st_reg == frs_pkg::FRS_ST_POWER |-> o_chip_select_n && o_busy;
	endproperty
	a_no_access_cold: assert property (p_no_access_cold) else $error("access in cold start");
	property p_ready_needs_rb;
		@(posedge i_clk_sys) disable iff (i_rst)
		$rose(o_ready) && $past(st_reg) == frs_pkg::FRS_ST_RST_HIGH |-> $past(i_ready_busy_n);
	endproperty
	a_ready_needs_rb: assert property (p_ready_needs_rb) else $error("ready while busy");
	property p_reset_req;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_ready && i_reset_req |=> !o_ready;
	endproperty
	a_reset_req: assert property (p_reset_req) else $error("reset request ignored");
	property p_no_cs_cycle;
		@(posedge i_clk_sys) disable iff (i_rst)
		cyc_reg == 0;
	endproperty
	a_no_cs_cycle: assert property (p_no_cs_cycle) else $error("select low outside ready");
	c_cold: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_ready));
	c_warm: cover property (@(posedge i_clk_sys) disable iff (i_rst) $fell(o_hw_reset_n));
	c_read: cover property (@(posedge i_clk_sys) disable iff (i_rst) $fell(o_chip_select_n));
endmodule
`default_nettype wire

// >>> core/frs_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "frs_defs.svh"
module frs_timer (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_load,
	input wire frs_pkg::frs_cnt_t i_count,
	output logic o_done
);
	frs_pkg::frs_cnt_t cnt_reg;
	frs_pkg::frs_cnt_t cnt_next;
	always_comb begin
		cnt_next = cnt_reg;
		if (i_load) begin
			cnt_next = i_count;
		end else if (cnt_reg != 16'h0000) begin
			cnt_next = cnt_reg - 16'h0001;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
	// Done is a pure register decode: the loader reads it, so it must not look back at i_load
	assign o_done = (cnt_reg == 16'h0000);
endmodule
`default_nettype wire

// >>> inc/frs_defs.svh
`ifndef FRS_DEFS_SVH
`define FRS_DEFS_SVH
`define FRS_CLK_NS 40
`define FRS_SUPPLY_SETUP_US 300
`define FRS_RESET_LOW_TO_SELECT_US 35
`define FRS_RESET_PULSE_NS 200
`define FRS_RESET_HIGH_TO_SELECT_NS 50
`define FRS_SELECT_HIGH_NS 20
`define FRS_SUPPLY_CYC ((`FRS_SUPPLY_SETUP_US * 1000 + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_RPH_CYC ((`FRS_RESET_LOW_TO_SELECT_US * 1000 + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_RP_CYC ((`FRS_RESET_PULSE_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_RH_CYC ((`FRS_RESET_HIGH_TO_SELECT_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_CEH_CYC ((`FRS_SELECT_HIGH_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_CNT_W 16
`endif

// >>> inc/frs_pkg.sv
package frs_pkg;
	typedef enum logic [2:0] {
		FRS_ST_POWER,
		FRS_ST_RST_LOW,
		FRS_ST_RST_WAIT,
		FRS_ST_RST_HIGH,
		FRS_ST_READY,
		FRS_ST_SEL_HIGH
	} frs_state_e;
	typedef logic [15:0] frs_cnt_t;
endpackage

// >>> sim/flash_reset_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_reset_sequencer_test;
	localparam int SUP = 20;
	localparam int RPH = 10;
	// Minimum reset pulse and reset-high-to-select, in 40 ns cycles
	localparam int RP = 5;
	localparam int RH = 2;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic i_reset_req = 1'b0;
	logic i_access_req = 1'b0;
	logic i_access_end = 1'b0;
	logic [15:0] warm_cyc = 16'h0004;
	logic rbn;
	logic o_hw_reset_n;
	logic o_chip_select_n;
	logic o_ready;
	logic o_busy;
	logic rn_q = 1'b1;
	logic cs_q = 1'b1;
	int since_fall = 1000;
	int since_rise = 1000;
	int errors = 0;
	int comparisons = 0;
	int n;
	always #20 i_clk_sys = ~i_clk_sys;
	frs_host #(.SUPPLY_CYC(SUP), .RPH_CYC(RPH)) u_frs_host (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_req(i_reset_req),
		.i_access_req(i_access_req), .i_access_end(i_access_end),
		.i_ready_busy_n(rbn), .o_hw_reset_n(o_hw_reset_n),
		.o_chip_select_n(o_chip_select_n), .o_ready(o_ready), .o_busy(o_busy)
	);
	frs_flash_model #(.COLD_CYC(15)) u_frs_flash_model (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_hw_reset_n(o_hw_reset_n),
		.i_warm_cyc(warm_cyc), .o_ready_busy_n(rbn)
	);
	task automatic report_and_stop();
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	// Pin spacing is watched on every falling edge, once the outputs have settled
	always @(negedge i_clk_sys) begin
		since_fall = since_fall + 1;
		since_rise = since_rise + 1;
		if (!i_rst) begin
			check(o_busy === ~o_ready, "busy not inverse of ready");
			if (cs_q && o_chip_select_n === 1'b0) begin
				check(since_fall >= RPH, "select too soon after reset fall");
				check(since_rise >= RH, "select too soon after reset rise");
				check(rbn === 1'b1, "select while flash busy");
			end
			if (!rn_q && o_hw_reset_n === 1'b1) begin
				check(since_fall >= RP, "reset pulse too short");
			end
		end
		if (rn_q && o_hw_reset_n === 1'b0) begin
			since_fall = 0;
		end
		if (!rn_q && o_hw_reset_n === 1'b1) begin
			since_rise = 0;
		end
		rn_q = o_hw_reset_n;
		cs_q = o_chip_select_n;
	end
	// Bounded wait for the host to report ready; n counts cycles
	task automatic wait_ready(input int lim);
		n = 0;
		while (o_ready !== 1'b1) begin
			@(negedge i_clk_sys);
			n++;
			if (n > lim) begin
				check(1'b0, "ready timeout");
				report_and_stop();
			end
		end
	endtask
	task automatic t_cold();
		wait_ready(500);
		check(n >= SUP, "access allowed before supply setup");
		check(o_hw_reset_n === 1'b1 && o_chip_select_n === 1'b1, "pins after cold");
	endtask
	task automatic t_reset(input logic [15:0] w);
		warm_cyc = w;
		i_reset_req = 1'b1;
		@(negedge i_clk_sys);
		i_reset_req = 1'b0;
		check(o_hw_reset_n === 1'b0 && o_ready === 1'b0, "reset not started");
		i_access_req = 1'b1;
		@(negedge i_clk_sys);
		i_access_req = 1'b0;
		wait_ready(500);
		check(n + 1 >= RPH && n + 1 >= int'(w), "ready before reset done");
		check(o_chip_select_n === 1'b1, "access taken during reset");
	endtask
	task automatic t_access();
		i_access_req = 1'b1;
		@(negedge i_clk_sys);
		i_access_req = 1'b0;
		check(o_chip_select_n === 1'b0, "select not low");
		i_access_end = 1'b1;
		@(negedge i_clk_sys);
		i_access_end = 1'b0;
		i_access_req = 1'b1;
		check(o_chip_select_n === 1'b1, "select not released");
		@(negedge i_clk_sys);
		i_access_req = 1'b0;
		i_access_end = 1'b1;
		@(negedge i_clk_sys);
		i_access_end = 1'b0;
		@(negedge i_clk_sys);
		check(o_chip_select_n === 1'b1, "select stuck low");
	endtask
	initial begin
		repeat (10) @(negedge i_clk_sys);
		i_rst = 1'b0;
		t_cold();
		t_access();
		t_reset(16'h0004);
		t_access();
		t_reset(16'h0028);
		i_rst = 1'b1;
		@(negedge i_clk_sys);
		check(o_hw_reset_n === 1'b1 && o_chip_select_n === 1'b1 && o_ready === 1'b0, "reset values");
		i_rst = 1'b0;
		t_cold();
		t_access();
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> sim/frs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module frs_flash_model #(
	parameter int COLD_CYC = 15
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_hw_reset_n,
	input wire logic [15:0] i_warm_cyc,
	output logic o_ready_busy_n
);
	logic done_reg;
	logic rn_reg;
	int cnt_reg;
	// Busy line has a pull-up, so it reads high when idle
	assign o_ready_busy_n = (cnt_reg == 0);
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			done_reg <= 1'b0;
			rn_reg <= 1'b1;
			cnt_reg <= COLD_CYC;
		end else begin
			rn_reg <= i_hw_reset_n;
			// Pins are ignored while an algorithm runs
			if (cnt_reg != 0) begin
				cnt_reg <= cnt_reg - 1;
				if (cnt_reg == 1) begin
					done_reg <= 1'b1;
				end
			end else if (rn_reg && !i_hw_reset_n) begin
				// Warm reset keeps the loaded state, so it counts i_warm_cyc instead of COLD_CYC
				cnt_reg <= done_reg ? int'(i_warm_cyc) : COLD_CYC;
			end
		end
	end
endmodule
`default_nettype wire
